/* src/i2csw_top.sv */
// i2c target holding the channel select byte of a bus switch
// assumes scl/sda arrive as open-drain pin levels; the wire is resolved outside
`timescale 1ns/1ps
`include "i2csw_cfg.svh"

// Overview of operation
// (R1) write address has read/write bit 0
// (R2) read address has read/write bit 1
// (R3) first write byte holds selection bits 2..0
// (R4) control bits 7 to 3 are ignored
// (R5) any byte count; last byte before stop kept
// (R6) new selection applied only at stop
// (R7) read returns control byte until controller nacks
// (R8) no limit on bytes read
// (R9) read shows selection now in force
// (R10) spikes up to 50 ns are filtered
// (R11) low reset pin clears register and state
// (R12) after reset no channel is connected
// (R13) address low bits come from pins
// (R14) write without stop leaves selection unchanged
module i2csw_top import i2csw_pkg::*; #(
  parameter int SEL_BITS = `I2CSW_SEL_BITS,
  parameter logic [4:0] ADDR_HI = `I2CSW_ADDR_HI
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_pin_0,
  input wire logic addr_pin_1,
  input wire logic reset_pin_n,
  output logic [7:0] chan_enable
);

  localparam logic [3:0] FILT_CYC = 4'(`I2CSW_FILT_CYC);

  generate
    if (SEL_BITS < 1 || SEL_BITS > 8) begin : g_bad_sel
      $error("SEL_BITS must lie between 1 and 8");
    end
    if (`I2CSW_FILT_CYC > 15) begin : g_bad_filt
      $error("spike filter count exceeds its counter");
    end
  endgenerate

  function automatic logic [7:0] ext_byte(input logic [SEL_BITS-1:0] sel);
    logic [7:0] b;
    b = `I2CSW_SEL_RESET;
    b[SEL_BITS-1:0] = sel;
    return b;
  endfunction

  // ************************************************************
  // link domain reset and pin synchronisers
  // ************************************************************
  logic [1:0] lrst_ff;
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lrst_ff <= 2'h3;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'h0};
    end
  end

  wire logic lrst = lrst_ff[1];

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      pin_s1_ff <= `I2CSW_PIN_IDLE;
      pin_s2_ff <= `I2CSW_PIN_IDLE;
    end else begin
      pin_s1_ff <= {reset_pin_n, addr_pin_1, addr_pin_0, sda_in, scl_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  wire logic pin_rst = ~pin_s2_ff[4];
  wire logic [1:0] addr_low = pin_s2_ff[3:2];
  wire logic [1:0] raw_line = pin_s2_ff[1:0];

  // ************************************************************
  // spike filter: a level is taken only once it has held long enough
  // ************************************************************
  i2csw_line_s filt_ff;
  i2csw_line_s prv_ff;
  logic [3:0] fcnt_ff [2];
  logic [3:0] nxt_fcnt [2];
  logic [1:0] nxt_filt;

  for (genvar i = 0; i < 2; i++) begin : g_filt
    assign nxt_fcnt[i] = (raw_line[i] == filt_ff[i]) ? `I2CSW_CNT_ZERO : fcnt_ff[i] + 4'h1;
    assign nxt_filt[i] = (nxt_fcnt[i] == FILT_CYC) ? raw_line[i] : filt_ff[i]; // [R10]
  end

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      filt_ff <= '1;
      prv_ff <= '1;
      fcnt_ff <= '{default: `I2CSW_CNT_ZERO};
    end else begin
      filt_ff <= nxt_filt;
      prv_ff <= filt_ff;
      fcnt_ff[0] <= (nxt_fcnt[0] == FILT_CYC) ? `I2CSW_CNT_ZERO : nxt_fcnt[0];
      fcnt_ff[1] <= (nxt_fcnt[1] == FILT_CYC) ? `I2CSW_CNT_ZERO : nxt_fcnt[1];
    end
  end

  wire logic scl_rise = filt_ff.scl & ~prv_ff.scl;
  wire logic scl_fall = ~filt_ff.scl & prv_ff.scl;
  wire logic scl_hi = filt_ff.scl & prv_ff.scl;
  wire logic start_det = scl_hi & prv_ff.sda & ~filt_ff.sda;
  wire logic stop_det = scl_hi & ~prv_ff.sda & filt_ff.sda;

  // ************************************************************
  // bus state machine
  // ************************************************************
  i2csw_state_e state_ff;
  i2csw_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic rw_ff;
  logic nxt_rw;
  logic ack_ff;
  logic nxt_ack;
  logic oe_ff;
  logic nxt_oe;
  logic [SEL_BITS-1:0] pend_ff;
  logic [SEL_BITS-1:0] nxt_pend;
  logic pvld_ff;
  logic nxt_pvld;
  logic [SEL_BITS-1:0] ctrl_ff;
  logic [SEL_BITS-1:0] nxt_ctrl;
  logic tog_ff;

  wire logic addr_match = (shift_ff[7:1] == {ADDR_HI, addr_low}); // [R13]
  wire logic [7:0] ctrl_byte = ext_byte(ctrl_ff); // [R9]
  wire logic last_bit = (cnt_ff == `I2CSW_LAST_BIT);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_ack = ack_ff;
    nxt_oe = oe_ff;
    nxt_pend = pend_ff;
    nxt_pvld = pvld_ff;
    nxt_ctrl = ctrl_ff;
    if (pin_rst) begin
      nxt_state = S_IDLE; // [R11]
      nxt_oe = 1'h0;
      nxt_pvld = 1'h0;
      nxt_ctrl = SEL_BITS'(`I2CSW_SEL_RESET); // [R12]
    end else if (start_det) begin
      nxt_state = S_ADDR;
      nxt_cnt = `I2CSW_CNT_ZERO;
      nxt_oe = 1'h0;
      nxt_pvld = 1'h0; // [R14]
    end else if (stop_det) begin
      nxt_state = S_IDLE;
      nxt_oe = 1'h0;
      nxt_pvld = 1'h0;
      if (pvld_ff) begin
        nxt_ctrl = pend_ff; // [R6]
      end
    end else if (scl_rise) begin
      if (state_ff == S_ADDR || state_ff == S_WR) begin
        nxt_shift = {shift_ff[6:0], filt_ff.sda};
        nxt_cnt = cnt_ff + 4'h1;
      end
      if (state_ff == S_RACK) begin
        nxt_ack = ~filt_ff.sda;
      end
    end else if (scl_fall) begin
      unique case (state_ff)
        S_IDLE: begin
          nxt_state = S_IDLE;
        end
        S_ADDR: begin
          if (last_bit) begin
            nxt_state = addr_match ? S_AACK : S_IDLE; // [R13]
            nxt_oe = addr_match; // [R1] [R2]
            nxt_rw = shift_ff[0];
          end
        end
        S_AACK: begin
          nxt_cnt = `I2CSW_FIRST_BIT;
          if (rw_ff == `I2CSW_RW_READ) begin
            nxt_state = S_RD;
            nxt_shift = ctrl_byte;
            nxt_oe = ~ctrl_byte[7]; // [R7]
          end else begin
            nxt_state = S_WR;
            nxt_cnt = `I2CSW_CNT_ZERO;
            nxt_oe = 1'h0;
          end
        end
        S_WR: begin
          if (last_bit) begin
            // only the selection bits are kept; every byte overwrites the last
            nxt_pend = shift_ff[SEL_BITS-1:0]; // [R3] [R4] [R5]
            nxt_pvld = 1'h1;
            nxt_state = S_WACK;
            nxt_oe = 1'h1;
          end
        end
        S_WACK: begin
          nxt_state = S_WR;
          nxt_cnt = `I2CSW_CNT_ZERO;
          nxt_oe = 1'h0;
        end
        S_RD: begin
          if (last_bit) begin
            nxt_state = S_RACK;
            nxt_oe = 1'h0;
          end else begin
            nxt_shift = {shift_ff[6:0], 1'h0};
            nxt_oe = ~shift_ff[6];
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        S_RACK: begin
          if (ack_ff) begin
            nxt_state = S_RD; // [R8]
            nxt_shift = ctrl_byte;
            nxt_oe = ~ctrl_byte[7];
            nxt_cnt = `I2CSW_FIRST_BIT;
          end else begin
            nxt_state = S_IDLE; // [R7]
          end
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      state_ff <= S_IDLE;
      cnt_ff <= `I2CSW_CNT_ZERO;
      shift_ff <= `I2CSW_SEL_RESET;
      rw_ff <= 1'h0;
      ack_ff <= 1'h0;
      oe_ff <= 1'h0;
      pend_ff <= '0;
      pvld_ff <= 1'h0;
      ctrl_ff <= '0;
      tog_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      ack_ff <= nxt_ack;
      oe_ff <= nxt_oe;
      pend_ff <= nxt_pend;
      pvld_ff <= nxt_pvld;
      ctrl_ff <= nxt_ctrl;
      tog_ff <= tog_ff ^ (nxt_ctrl != ctrl_ff);
    end
  end

  // the pin only ever pulls low
  assign sda_oe = oe_ff;
  assign sda_out = 1'h0;

  // ************************************************************
  // system clock side: switch enables
  // ************************************************************
  // ctrl_ff changes only at a stop or a pin reset, so it is long stable when the toggle lands
  logic [2:0] tsync_ff;
  logic [7:0] en_ff;

  wire logic tog_edge = tsync_ff[2] ^ tsync_ff[1];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tsync_ff <= 3'h0;
      en_ff <= `I2CSW_SEL_RESET;
    end else begin
      tsync_ff <= {tsync_ff[1:0], tog_ff};
      en_ff <= tog_edge ? ctrl_byte : en_ff; // [R6] [R12]
    end
  end

  assign chan_enable = en_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  a_spike_filter: assert property (@(posedge link_clk) disable iff (lrst) // [R10]
    (filt_ff.scl != $past(filt_ff.scl)) |-> ($past(fcnt_ff[0]) == FILT_CYC - 4'h1))
    else $error("scl level taken before the filter time");

  a_addr_ack: assert property (@(posedge link_clk) disable iff (lrst) // [R13]
    (scl_fall && state_ff == S_ADDR && last_bit && addr_match && !pin_rst) |=> (state_ff == S_AACK && sda_oe))
    else $error("matching address not acknowledged");

  a_addr_ignore: assert property (@(posedge link_clk) disable iff (lrst) // [R13]
    (scl_fall && state_ff == S_ADDR && last_bit && !addr_match && !pin_rst) |=> (state_ff == S_IDLE && !sda_oe))
    else $error("foreign address acknowledged");

  a_last_byte: assert property (@(posedge link_clk) disable iff (lrst) // [R5]
    (scl_fall && state_ff == S_WR && last_bit && !pin_rst) |=> (pvld_ff && pend_ff == $past(shift_ff[SEL_BITS-1:0])))
    else $error("written byte not held as pending selection");

  a_commit_stop: assert property (@(posedge link_clk) disable iff (lrst) // [R6]
    (ctrl_ff != $past(ctrl_ff)) |-> ($past(stop_det) || $past(pin_rst)))
    else $error("selection changed outside stop");

  a_abort_keep: assert property (@(posedge link_clk) disable iff (lrst) // [R14]
    (start_det && !pin_rst) |=> (!pvld_ff ##1 $stable(ctrl_ff)))
    else $error("aborted write still pending");

  a_read_first: assert property (@(posedge link_clk) disable iff (lrst) // [R7]
    (scl_fall && state_ff == S_AACK && rw_ff && !pin_rst) |=> (state_ff == S_RD && sda_oe == ~ctrl_byte[7]))
    else $error("read does not start with control byte");

  a_nack_end: assert property (@(posedge link_clk) disable iff (lrst) // [R7]
    (scl_fall && state_ff == S_RACK && !ack_ff && !pin_rst && !start_det) |=> (state_ff == S_IDLE && !sda_oe))
    else $error("read continues after nack");

  a_pin_reset: assert property (@(posedge link_clk) disable iff (lrst) // [R11]
    pin_rst |=> (ctrl_ff == '0 && state_ff == S_IDLE && !sda_oe))
    else $error("reset pin did not clear state");

  a_enable_follow: assert property (@(posedge clk) disable iff (reset) // [R6]
    (chan_enable != $past(chan_enable)) |-> $past(tog_edge))
    else $error("switch enables changed without a commit");

endmodule

/* src/i2csw_cfg.svh */
// constants for the i2c channel switch control block
// assumes a 100 MHz system clock and a link sampling clock of the period below
`ifndef I2CSW_CFG_SVH
`define I2CSW_CFG_SVH

`define I2CSW_SEL_BITS 3
`define I2CSW_ADDR_HI 5'h1C
`define I2CSW_LAST_BIT 4'h8
`define I2CSW_FIRST_BIT 4'h1
`define I2CSW_CNT_ZERO 4'h0
`define I2CSW_RW_READ 1'h1
`define I2CSW_SEL_RESET 8'h00
`define I2CSW_PIN_IDLE 5'h1F
`define I2CSW_SPIKE_NS 50
`define I2CSW_LINK_PERIOD_PS 6000
// a spike covers at most ceil(spike/period) samples, so one more sample is needed
`define I2CSW_FILT_CYC ((`I2CSW_SPIKE_NS * 1000 + `I2CSW_LINK_PERIOD_PS - 1) / `I2CSW_LINK_PERIOD_PS + 1)

`endif

/* src/i2csw_pkg.sv */
// types shared by the i2c channel switch control block
// assumes nothing beyond a systemverilog compiler
package i2csw_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_WR   = 3'b011,
    S_WACK = 3'b100,
    S_RD   = 3'b101,
    S_RACK = 3'b110
  } i2csw_state_e;

  typedef struct packed {
    logic sda;
    logic scl;
  } i2csw_line_s;

endpackage

/* testbench/i2csw_ctrl_model.sv */
// upstream i2c controller model driving scl and sda as open-drain pulls
// assumes the bench resolves both wires with pull-ups and feeds sda back
`timescale 1ns/1ps

module i2csw_ctrl_model #(
  parameter int Q = 150
) (
  input wire logic sda_wire,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end

  // ****************************************
  // bus conditions and bits
  // ****************************************
  // quarter period of 150 ns keeps setup and hold well above the input filter
  task automatic start();
    sda_low = 1'h0;
    #Q scl_low = 1'h0;
    #Q sda_low = 1'h1;
    #Q scl_low = 1'h1;
    #Q;
  endtask

  task automatic stop();
    sda_low = 1'h1;
    #Q scl_low = 1'h0;
    #Q sda_low = 1'h0;
    #(4 * Q);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #Q scl_low = 1'h0;
    #Q r = sda_wire;
    #Q scl_low = 1'h1;
    #Q;
  endtask

  // address byte carries the direction in bit 0; ack bit sent last
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(last, ack);
  endtask

  // a 40 ns low spike on sda while scl is high, narrower than a valid start
  task automatic spike();
    #Q scl_low = 1'h0;
    #Q sda_low = 1'h1;
    #40 sda_low = 1'h0;
    #Q scl_low = 1'h1;
    #Q;
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the i2c channel switch control block
// assumes the controller model above and pull-ups on both bus wires
`timescale 1ns/1ps

module testbench;
  localparam logic [4:0] AHI = 5'h1C;
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic reset = 1'h1;
  logic reset_pin_n = 1'h1;
  logic addr_pin_0 = 1'h0;
  logic addr_pin_1 = 1'h1;
  logic sda_out, sda_oe, scl_low, sda_low, ack;
  logic [7:0] chan_enable, rx;
  wire sda_wire = ~((sda_oe & ~sda_out) | sda_low);
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] rows [5] = '{16'h0707, 16'hF800, 16'hA505, 16'h5A02, 16'h0000};

  i2csw_top #(.ADDR_HI(AHI)) dut (.clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(~scl_low),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_0(addr_pin_0),
    .addr_pin_1(addr_pin_1), .reset_pin_n(reset_pin_n), .chan_enable(chan_enable));
  i2csw_ctrl_model m (.sda_wire(sda_wire), .scl_low(scl_low), .sda_low(sda_low));

  initial forever #5 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic addr(input logic [1:0] lo, input logic rw);
    m.start();
    m.byte_io({AHI, lo, rw}, 1'h1, rx, ack);
  endtask

  task automatic wr(input logic [7:0] d);
    m.byte_io(d, 1'h1, rx, ack);
    chk("data ack", 8'h00, {7'h00, ack});
  endtask

  task automatic rd(input logic [7:0] exp, input logic nack);
    m.byte_io(8'hFF, nack, rx, ack);
    chk("read byte", exp, rx);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // runaway guard: the whole sequence needs about 25000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    repeat (20) @(posedge clk);
    #2;
    chk("chan after reset", 8'h00, chan_enable);
    chk("oe after reset", 8'h00, {7'h00, sda_oe});
    foreach (rows[i]) begin
      addr(2'h2, 1'h0);
      chk("write addr ack", 8'h00, {7'h00, ack});
      wr(rows[i][15:8]);
      m.stop();
      chk("chan", rows[i][7:0], chan_enable);
      addr(2'h2, 1'h1);
      chk("read addr ack", 8'h00, {7'h00, ack});
      rd(rows[i][7:0], 1'h0);
      rd(rows[i][7:0], 1'h1);
      m.stop();
    end
    addr(2'h2, 1'h0);
    wr(8'h01);
    wr(8'h06);
    chk("chan before stop", 8'h00, chan_enable);
    m.stop();
    chk("chan last byte", 8'h06, chan_enable);
    addr(2'h2, 1'h0);
    wr(8'h01);
    addr(2'h2, 1'h1);
    rd(8'h06, 1'h1);
    m.stop();
    chk("chan aborted write", 8'h06, chan_enable);
    addr(2'h1, 1'h0);
    chk("foreign addr ack", 8'h01, {7'h00, ack});
    m.byte_io(8'h07, 1'h1, rx, ack);
    m.stop();
    chk("chan foreign", 8'h06, chan_enable);
    // the address must follow the select pins, not a fixed value
    @(posedge clk);
    addr_pin_0 <= 1'h1;
    addr_pin_1 <= 1'h0;
    repeat (5) @(posedge clk);
    addr(2'h1, 1'h1);
    chk("pin addr ack", 8'h00, {7'h00, ack});
    rd(8'h06, 1'h1);
    m.stop();
    @(posedge clk);
    addr_pin_0 <= 1'h0;
    addr_pin_1 <= 1'h1;
    repeat (5) @(posedge clk);
    addr(2'h2, 1'h0);
    wr(8'h03);
    m.spike();
    m.stop();
    chk("chan after spike", 8'h03, chan_enable);
    @(posedge clk);
    reset_pin_n <= 1'h0;
    repeat (20) @(posedge clk);
    reset_pin_n <= 1'h1;
    repeat (20) @(posedge clk);
    #2;
    chk("chan after pin reset", 8'h00, chan_enable);
    addr(2'h2, 1'h1);
    rd(8'h00, 1'h1);
    m.stop();
    tally_and_finish();
  end
endmodule
